// file: lmsac_map.svh
// Purpose: Named constants for the logic cluster with shared arithmetic chains.
// Assumes: Included by its bare name.
// Notes: Definitions only.
`ifndef LMSAC_MAP_SVH
`define LMSAC_MAP_SVH
`define LMSAC_NMOD 10
`define LMSAC_BITS_PER_MOD 2
`define LMSAC_LUTS_PER_MOD 4
`define LMSAC_START_LO 0
`define LMSAC_START_HI 5
`define LMSAC_NUM_CLR 2
`define LMSAC_ZERO 1'h0
`define LMSAC_ONE 1'h1
`endif

// file: lmsac_pkg.sv
// Purpose: Types shared by the logic cluster.
// Assumes: Nothing beyond the map header.
// Notes: Only types live here.
package lmsac_pkg;
  // Three operand bits for the two bit positions of one logic module.
  typedef struct packed {
    logic [1:0] a;
    logic [1:0] b;
    logic [1:0] c;
  } lmsac_triple_t;

  // Static configuration of one logic module.
  typedef struct packed {
    logic sarith;
    logic regchain;
    logic lutreg;
    logic inv;
    logic clr_sel;
  } lmsac_mcfg_t;

  // Chain signals crossing a cluster boundary.
  typedef struct packed {
    logic shared;
    logic carry;
  } lmsac_chain_t;
endpackage

// file: lmsac_cluster.sv
// Purpose: One logic cluster of logic modules in shared arithmetic mode.
// Assumes: Inputs synchronous to core_clk; configuration held static.
// Notes: Registers run on a glitch-free gated cluster clock.
`timescale 1ns/10ps
`include "lmsac_map.svh"

// How it works
// - Four LUTs per module give sum or carry of three operand bits.
// - LUT carry rides shared chain to next adder, same or next module.
// - LUTs form partial sum and carry; adders produce final result.
// - Shared chains start only at the first or sixth module.
// - Chains over ten modules continue through cluster chain ports.
// - Column parameter picks top or bottom half bypass for the chain.
// - Third register is upper LUT half master, lower half slave latch.
// - LUT register shares clock, enable and clear with top register.
// - Register chain feeds each top register output to next module top register.
// - LUT outputs stay usable while registers form a shift register.
// - Registers clear asynchronously; preset via data inversion both sides.
// - Each cluster has at most two distinct clear signals.
// - Enabled device-wide clear clears every register and wins always.
// - Unused adders have sum and shared inputs held low; carry passes through.
// - Cluster clock one always goes with cluster clock enable one.
// - One gated clock drives all registers; enable low stops it.
// - Carry in feeds first adder, then second, then next module.
module lmsac_cluster #(
  parameter int NMOD = `LMSAC_NMOD,
  parameter bit TOP_BYPASSABLE = 1'h1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cluster_clock_enable_one,
  input wire logic [`LMSAC_NUM_CLR-1:0] cluster_clear_n,
  input wire logic device_wide_clear_n,
  input wire logic dev_clr_enable,
  input wire logic half_bypass,
  input wire logic start_sixth,
  input wire lmsac_pkg::lmsac_mcfg_t [NMOD-1:0] mcfg,
  input wire lmsac_pkg::lmsac_triple_t [NMOD-1:0] opnd,
  input wire lmsac_pkg::lmsac_chain_t chain_in,
  input wire logic reg_chain_in,
  output lmsac_pkg::lmsac_chain_t chain_out,
  output logic reg_chain_out,
  output logic [NMOD-1:0] lut_out,
  output logic [NMOD-1:0] top_q,
  output logic [NMOD-1:0] bot_q,
  output logic [NMOD-1:0] lut_q
);

  localparam int NB = NMOD * `LMSAC_BITS_PER_MOD;
  localparam int HI = `LMSAC_START_HI;
  localparam int LO = `LMSAC_START_LO;

  // ==========================================================
  // Gated cluster clock
  // ==========================================================
  logic en_lat;
  logic gclk;

  always_latch begin
    if (!core_clk) begin
      en_lat = cluster_clock_enable_one;
    end
  end

  assign gclk = core_clk & en_lat;

  // ==========================================================
  // Clear selection
  // ==========================================================
  logic dev_clr;
  logic [NMOD-1:0] clr_m;

  assign dev_clr = dev_clr_enable & ~device_wide_clear_n;

  function automatic logic sel_clr(input logic sel,
                                   input logic [`LMSAC_NUM_CLR-1:0] cn);
    sel_clr = ~cn[sel];
  endfunction

  // ==========================================================
  // Chain participation
  // ==========================================================
  logic byp_top;
  logic byp_bot;
  logic [NMOD-1:0] used;

  assign byp_top = half_bypass & TOP_BYPASSABLE;
  assign byp_bot = half_bypass & ~TOP_BYPASSABLE;

  always_comb begin
    for (int m = 0; m < NMOD; m++) begin
      used[m] = mcfg[m].sarith;
      if ((byp_top || start_sixth) && m < HI) begin
        used[m] = `LMSAC_ZERO;
      end
      if (byp_bot && m >= HI) begin
        used[m] = `LMSAC_ZERO;
      end
    end
  end

  // ==========================================================
  // LUT stage and adder chain
  // ==========================================================
  logic [NB-1:0] va;
  logic [NB-1:0] vb;
  logic [NB-1:0] vc;
  logic [NB-1:0] psum;
  logic [NB-1:0] pcar;
  logic [NB-1:0] res;
  logic sh_last;
  logic cy_last;

  generate
    for (genvar m = 0; m < NMOD; m++) begin : g_bits
      assign va[2*m+1:2*m] = opnd[m].a;
      assign vb[2*m+1:2*m] = opnd[m].b;
      assign vc[2*m+1:2*m] = opnd[m].c;
    end
  endgenerate

  assign psum = va ^ vb ^ vc;
  assign pcar = (va & vb) | (va & vc) | (vb & vc);

  always_comb begin
    logic sh;
    logic cy;
    logic x;
    logic y;
    int m;
    sh = `LMSAC_ZERO;
    cy = `LMSAC_ZERO;
    x = `LMSAC_ZERO;
    y = `LMSAC_ZERO;
    m = 0;
    res = '0;
    sh_last = `LMSAC_ZERO;
    cy_last = `LMSAC_ZERO;
    for (int j = 0; j < NB; j++) begin
      m = j / `LMSAC_BITS_PER_MOD;
      // chain entry at first or sixth module.
      if ((j % `LMSAC_BITS_PER_MOD) == 0 && m == LO && !byp_top && !start_sixth) begin
        sh = chain_in.shared;
        cy = chain_in.carry;
      end
      if ((j % `LMSAC_BITS_PER_MOD) == 0 && m == HI) begin
        if (start_sixth) begin
          sh = `LMSAC_ZERO;
          cy = `LMSAC_ZERO;
        end else if (byp_top) begin
          sh = chain_in.shared;
          cy = chain_in.carry;
        end
      end
      if (used[m]) begin
        x = psum[j];
        y = sh;
        res[j] = x ^ y ^ cy;
        cy = (x & y) | (cy & (x ^ y));
        sh = pcar[j];
        sh_last = sh;
        cy_last = cy;
      end else begin
        x = `LMSAC_ZERO;
        y = `LMSAC_ZERO;
        res[j] = `LMSAC_ZERO;
      end
    end
  end

  assign chain_out.shared = sh_last;
  assign chain_out.carry = cy_last;

  assign lut_out = psum[NB-1:0] == '0 ? '0 : {NMOD{`LMSAC_ZERO}} | lut_fn(psum);

  function automatic logic [NMOD-1:0] lut_fn(input logic [NB-1:0] s);
    logic [NMOD-1:0] o;
    o = '0;
    for (int k = 0; k < NMOD; k++) begin
      o[k] = s[2*k];
    end
    return o;
  endfunction

  // ==========================================================
  // Module registers
  // ==========================================================
  logic [NMOD-1:0] top_r;
  logic [NMOD-1:0] bot_r;
  logic [NMOD-1:0] top_nxt;
  logic [NMOD-1:0] bot_nxt;
  logic [NMOD-1:0] mst_l;
  logic [NMOD-1:0] slv_l;

  always_comb begin
    for (int m = 0; m < NMOD; m++) begin
      clr_m[m] = rst | dev_clr | sel_clr(mcfg[m].clr_sel, cluster_clear_n);
      if (mcfg[m].regchain) begin
        top_nxt[m] = (m == 0 ? reg_chain_in : top_q[m == 0 ? 0 : m-1]) ^ mcfg[m].inv;
      end else begin
        top_nxt[m] = res[2*m] ^ mcfg[m].inv;
      end
      bot_nxt[m] = res[2*m+1] ^ mcfg[m].inv;
    end
  end

  generate
    for (genvar m = 0; m < NMOD; m++) begin : g_reg
      always_ff @(posedge gclk or posedge clr_m[m]) begin
        if (clr_m[m]) begin
          top_r[m] <= `LMSAC_ZERO;
          bot_r[m] <= `LMSAC_ZERO;
        end else begin
          top_r[m] <= top_nxt[m];
          bot_r[m] <= bot_nxt[m];
        end
      end

      always_latch begin
        if (clr_m[m]) begin
          mst_l[m] = `LMSAC_ZERO;
        end else if (!gclk && mcfg[m].lutreg) begin
          mst_l[m] = psum[2*m+1] ^ mcfg[m].inv;
        end
      end

      always_latch begin
        if (clr_m[m]) begin
          slv_l[m] = `LMSAC_ZERO;
        end else if (gclk) begin
          slv_l[m] = mst_l[m];
        end
      end

      assign top_q[m] = top_r[m] ^ mcfg[m].inv;
      assign bot_q[m] = bot_r[m] ^ mcfg[m].inv;
      assign lut_q[m] = slv_l[m] ^ mcfg[m].inv;
    end
  endgenerate

  assign reg_chain_out = top_q[NMOD-1];

endmodule // lmsac_cluster

// file: lmsac_prev_cluster.sv
// Purpose: Previous cluster in the column, seen through its chain wires.
// Assumes: Shares core_clk and rst with the cluster under test.
// Notes: The register chain bit toggles every cycle.
`timescale 1ns/10ps
module lmsac_prev_cluster (
  input wire logic core_clk,
  input wire logic rst,
  output lmsac_pkg::lmsac_chain_t chain_out,
  output logic reg_q
);
  assign chain_out = 2'h0;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_q <= 1'h0;
    end else begin
      reg_q <= ~reg_q;
    end
  end
endmodule // lmsac_prev_cluster

// file: lmsac_cluster_chk.sv
// Purpose: Port assertions for the logic cluster.
// Assumes: Bound into lmsac_cluster.
// Notes: Cleared outputs equal each module's inversion bit.
`timescale 1ns/10ps
module lmsac_cluster_chk #(
  parameter int NMOD = 10
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cluster_clock_enable_one,
  input wire logic [1:0] cluster_clear_n,
  input wire logic device_wide_clear_n,
  input wire logic dev_clr_enable,
  input wire logic half_bypass,
  input wire logic start_sixth,
  input wire lmsac_pkg::lmsac_chain_t chain_in,
  input wire lmsac_pkg::lmsac_mcfg_t [NMOD-1:0] mcfg,
  input wire lmsac_pkg::lmsac_triple_t [NMOD-1:0] opnd,
  input wire logic reg_chain_out,
  input wire logic [NMOD-1:0] top_q,
  input wire logic [NMOD-1:0] bot_q,
  input wire logic [NMOD-1:0] lut_q
);
  // ==========================================================
  // Helpers and assertions.
  logic [NMOD-1:0] inv_v;
  logic [NMOD-1:0] sel_v;
  logic nc;
  logic s0;
  always_comb begin
    for (int m = 0; m < NMOD; m++) begin
      inv_v[m] = mcfg[m].inv;
      sel_v[m] = mcfg[m].clr_sel;
    end
  end
  assign nc = (cluster_clear_n == 2'h3) && (device_wide_clear_n || !dev_clr_enable);
  assign s0 = opnd[0].a[0] ^ opnd[0].b[0] ^ opnd[0].c[0] ^ chain_in.shared ^ chain_in.carry;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_dev_clear_all: assert property (dev_clr_enable && !device_wide_clear_n |=>
    top_q == inv_v && bot_q == inv_v) else $error("device clear missed");
  a_clear_first: assert property (!cluster_clear_n[0] |=>
    (top_q & ~sel_v) == (inv_v & ~sel_v)) else $error("first clear missed");
  a_clear_second: assert property (!cluster_clear_n[1] |=>
    (bot_q & sel_v) == (inv_v & sel_v)) else $error("second clear missed");
  a_gate_top_hold: assert property (!cluster_clock_enable_one && nc ##1 nc |->
    $stable(top_q)) else $error("top register clocked while gated");
  a_gate_bot_hold: assert property (!cluster_clock_enable_one && nc ##1 nc |->
    $stable(bot_q)) else $error("bottom register clocked while gated");
  a_lut_reg_hold: assert property ((!cluster_clock_enable_one && nc) ##1 nc |->
    lut_q == $past(lut_q)) else $error("lut register ignored enable");
  a_reg_chain_end: assert property (reg_chain_out == top_q[NMOD-1])
    else $error("register chain end wrong");
  a_bit_zero_sum: assert property (cluster_clock_enable_one && nc && mcfg[0].sarith
    && !mcfg[0].regchain && !start_sixth && !half_bypass ##1 nc |-> top_q[0] == $past(s0))
    else $error("bit zero wrong");
endmodule // lmsac_cluster_chk
bind lmsac_cluster lmsac_cluster_chk #(.NMOD(NMOD)) u_lmsac_cluster_chk (.core_clk, .rst,
  .cluster_clock_enable_one, .cluster_clear_n, .device_wide_clear_n, .dev_clr_enable,
  .half_bypass, .start_sixth, .chain_in,
  .mcfg, .opnd, .reg_chain_out, .top_q, .bot_q, .lut_q);

// file: lmsac_cluster_bench.sv
// Purpose: Self-checking bench for the logic cluster.
// Assumes: 200 MHz clock, reset held 20 cycles.
// Notes: The model sums three 20-bit operands.
`timescale 1ns/10ps
module lmsac_cluster_bench;
  // ==========================================================
  // Bench.
  localparam int N = 10;
  localparam int HI = 5;
  logic core_clk, rst, en, dce, dcn, reg_chain_in, reg_chain_out, s6;
  lmsac_pkg::lmsac_chain_t chain_out;
  logic [N-1:0] lut_out, elut, elo;
  int ech;
  logic [1:0] ccn;
  lmsac_pkg::lmsac_mcfg_t [N-1:0] mcfg;
  lmsac_pkg::lmsac_triple_t [N-1:0] opnd;
  lmsac_pkg::lmsac_chain_t chain_in;
  logic [N-1:0] top_q, bot_q, lut_q, etop, ebot, inv_v;
  int failures, tests_run, seed;
  lmsac_prev_cluster u_lmsac_prev_cluster (.core_clk, .rst, .chain_out(chain_in),
    .reg_q(reg_chain_in));
  lmsac_cluster #(.NMOD(N)) u_lmsac_cluster (.core_clk, .rst, .cluster_clock_enable_one(en),
    .cluster_clear_n(ccn), .device_wide_clear_n(dcn), .dev_clr_enable(dce),
    .half_bypass(1'h0), .start_sixth(s6), .mcfg, .opnd, .chain_in, .reg_chain_in,
    .chain_out, .reg_chain_out, .lut_out, .top_q, .bot_q, .lut_q);
  task automatic chk(input logic [N-1:0] got, input logic [N-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk2();
    chk(top_q, etop);
    chk(bot_q, ebot);
    chk(lut_q, elut);
  endtask
  task automatic add_round();
    int s;
    int base;
    @(posedge core_clk);
    en <= 1'h1;
    for (int m = 0; m < N; m++) begin
      opnd[m] <= 6'($random(seed));
    end
    @(posedge core_clk);
    @(negedge core_clk);
    s = 0;
    base = s6 ? HI : 0;
    etop = '0;
    ebot = '0;
    for (int m = base; m < N; m++) begin
      s += (int'(opnd[m].a) + int'(opnd[m].b) + int'(opnd[m].c)) << (2 * (m - base));
    end
    for (int m = base; m < N; m++) begin
      etop[m] = s[2 * (m - base)];
      ebot[m] = s[2 * (m - base) + 1];
    end
    for (int m = 0; m < N; m++) begin
      elut[m] = opnd[m].a[1] ^ opnd[m].b[1] ^ opnd[m].c[1];
      elo[m] = opnd[m].a[0] ^ opnd[m].b[0] ^ opnd[m].c[0];
    end
    ech = s >>> (2 * (N - base));
  endtask
  task automatic complete_run();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    failures++;
    complete_run();
  end
  initial begin
    seed = 40504;
    s6 = 1'h0;
    rst = 1'h1;
    en = 1'h0;
    dce = 1'h0;
    dcn = 1'h1;
    ccn = 2'h3;
    opnd = '0;
    for (int m = 0; m < N; m++) begin
      mcfg[m] = {1'h1, 1'h0, 1'h1, 1'(m == 3), 1'(m % 2)};
      inv_v[m] = 1'(m == 3);
    end
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    repeat (40) begin
      add_round();
      chk2();
      chk(lut_out, elo);
      chk(N'(int'(chain_out.shared) + int'(chain_out.carry)), N'(ech));
    end
    @(posedge core_clk);
    en <= 1'h0;
    opnd <= ~opnd;
    @(posedge core_clk);
    @(negedge core_clk);
    chk2();
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      ccn[k] <= 1'h0;
      for (int m = 0; m < N; m++) begin
        if (m % 2 == k) begin
          etop[m] = inv_v[m];
          ebot[m] = inv_v[m];
          elut[m] = inv_v[m];
        end
      end
      @(negedge core_clk);
      chk2();
      @(posedge core_clk);
      ccn[k] <= 1'h1;
    end
    add_round();
    chk2();
    @(posedge core_clk);
    en <= 1'h0;
    dcn <= 1'h0;
    @(negedge core_clk);
    chk2();
    @(posedge core_clk);
    dce <= 1'h1;
    en <= 1'h1;
    etop = inv_v;
    ebot = inv_v;
    elut = inv_v;
    @(negedge core_clk);
    chk2();
    @(posedge core_clk);
    @(posedge core_clk);
    rst <= 1'h1;
    en <= 1'h0;
    dcn <= 1'h1;
    @(negedge core_clk);
    chk2();
    @(posedge core_clk);
    rst <= 1'h0;
    add_round();
    chk2();
    s6 <= 1'h1;
    add_round();
    chk2();
    chk(N'(int'(chain_out.shared) + int'(chain_out.carry)), N'(ech));
    complete_run();
  end
endmodule // lmsac_cluster_bench
